// ### hdl/acr_params.svh
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH
// destination select codes on data bits 9:8
`define ACR_SEL_CLAMP_LOW 2'h0
`define ACR_SEL_CLAMP_HIGH 2'h1
`define ACR_SEL_CONTROL 2'h2
`define ACR_SEL_RESERVED 2'h3
// register offsets (same as select codes)
`define ACR_OFS_CLAMP_LOW 2'h0
`define ACR_OFS_CLAMP_HIGH 2'h1
`define ACR_OFS_CONTROL 2'h2
// reset values
`define ACR_RST_CLAMP_LOW 8'h00
`define ACR_RST_CLAMP_HIGH 8'h00
`define ACR_RST_CONTROL 8'h01
// control field positions
`define ACR_CTL_GAIN_LSB 0
`define ACR_CTL_GAIN_MSB 2
`define ACR_CTL_SLEEP 3
`define ACR_CTL_CLAMP_SRC 4
`define ACR_CTL_SIGNED 5
`define ACR_CTL_CLAMP_OFF 6
// select field position on the data pins
`define ACR_SEL_LSB 8
`define ACR_SEL_MSB 9
// synchroniser depth for pin inputs
`define ACR_SYNC_STAGES 3
`endif

// ### hdl/acr_pkg.sv
package acr_pkg;
  // write-strobe capture states
  typedef enum logic [1:0] {
    ACR_IDLE = 2'b00,
    ACR_HIGH = 2'b01
  } acr_wr_state_t;
  // gain in half steps (1 = 0.5 ... 8 = 4.0)
  typedef logic [3:0] acr_half_gain_t;
endpackage : acr_pkg

// ### hdl/acr_sync.sv
`timescale 1ns/1ps
`include "acr_params.svh"
// three-stage synchroniser; change accepted when stages 2 and 3 agree
module acr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_ff; // first stage, read only by stage 2
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] q_ff;  // filtered result
  genvar i;

  // shift chain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else if (ce) begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // per-bit agreement filter
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          q_ff[i] <= 1'b0;
        end else if (ce && (s2_ff[i] == s3_ff[i])) begin
          q_ff[i] <= s3_ff[i];
        end
      end
    end
  endgenerate

  assign dout = q_ff;
endmodule : acr_sync

// ### hdl/acr_regs.sv
`timescale 1ns/1ps
`include "acr_params.svh"
// What this block does
// (RQ1) host loads words via data pins, strobe
// (RQ2) bits 9:8 pick low, high, control
// (RQ3) registers write-only, never read back
// (RQ4) host never writes select code 11
// (RQ5) gain field 000..111 is 0.5..4.0
// (RQ6) control bit 3 sets power-down
// (RQ7) control bit 4 picks clamp source
// (RQ8) control bit 5 picks two's complement
// (RQ9) control bit 6 turns clamp pin off
// (RQ10) clamp code from low and high registers
// (RQ11) code zero bottom, full-scale top reference
// (RQ12) drivers tri-state while enable pin high
// (RQ13) word latched on strobe high then low
// (RQ14) enable low drives results, pin 0 LSB
// (RQ15) reserved select writes are ignored
module acr_regs (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic wr_pin,
  input wire logic oe_n_pin,
  input wire logic [9:0] data_in,
  output logic [9:0] data_out,
  output logic data_oe_n,
  output logic over_range_out,
  output logic over_range_oe_n,
  input wire logic [9:0] conv_result,
  input wire logic conv_over_range,
  output logic [2:0] gain_select,
  output logic [3:0] gain_half_steps,
  output logic sleep_bit,
  output logic clamp_source_sel,
  output logic signed_output_sel,
  output logic clamp_out_off,
  output logic [9:0] clamp_code
);
  logic [9:0] data_s; // synchronised data pins
  logic wr_s; // synchronised strobe
  logic oe_drive_s; // synchronised drive request, high = drive
  logic oe_n_s; // synchronised drive enable, active low
  acr_pkg::acr_wr_state_t st_ff;
  acr_pkg::acr_wr_state_t nxt_st;
  logic [9:0] word_ff; // word held while strobe high
  logic commit; // falling strobe edge
  logic [7:0] clamp_low_ff;
  logic [7:0] clamp_high_ff;
  logic [7:0] control_ff;
  logic [9:0] dout_ff;
  logic over_range_ff; // registered over-range flag

  // decode: is this select a real destination
  function automatic logic sel_valid(input logic [1:0] sel);
    sel_valid = (sel != `ACR_SEL_RESERVED);
  endfunction : sel_valid

  // pins come from another domain; bundle them through one synchroniser
  // enable goes in inverted so the chain's reset value means drivers off
  acr_sync #(.WIDTH(12)) u_acr_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .din({~oe_n_pin, wr_pin, data_in}),
    .dout({oe_drive_s, wr_s, data_s})
  );
  // back to active-low sense; no bus fight with the host after reset
  assign oe_n_s = ~oe_drive_s; // RQ12

  // strobe state: capture while high, commit on return low
  always_comb begin
    nxt_st = st_ff;
    commit = 1'b0;
    case (st_ff)
      acr_pkg::ACR_IDLE: begin
        if (wr_s && oe_n_s) begin
          nxt_st = acr_pkg::ACR_HIGH; // RQ12
        end
      end
      acr_pkg::ACR_HIGH: begin
        if (!wr_s) begin
          nxt_st = acr_pkg::ACR_IDLE;
          commit = 1'b1; // RQ13
        end
      end
      default: nxt_st = acr_pkg::ACR_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_ff <= acr_pkg::ACR_IDLE;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  // keep the last word seen while strobe high; the falling edge may blur data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      word_ff <= 10'h000;
    end else if (ce && wr_s) begin
      word_ff <= data_s; // RQ1
    end
  end

  // destination decode and write; reserved select dropped
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      clamp_low_ff <= `ACR_RST_CLAMP_LOW;
      clamp_high_ff <= `ACR_RST_CLAMP_HIGH;
      control_ff <= `ACR_RST_CONTROL;
    end else if (ce && commit && sel_valid(word_ff[`ACR_SEL_MSB:`ACR_SEL_LSB])) begin // RQ15
      case (word_ff[`ACR_SEL_MSB:`ACR_SEL_LSB]) // RQ2
        `ACR_SEL_CLAMP_LOW: clamp_low_ff <= word_ff[7:0];
        `ACR_SEL_CLAMP_HIGH: clamp_high_ff <= word_ff[7:0];
        `ACR_SEL_CONTROL: control_ff <= word_ff[7:0];
        default: ;
      endcase
    end
  end

  // control fields; bit 7 unused
  assign gain_select = control_ff[`ACR_CTL_GAIN_MSB:`ACR_CTL_GAIN_LSB];
  assign gain_half_steps = {1'b0, gain_select} + 4'h1; // RQ5
  assign sleep_bit = control_ff[`ACR_CTL_SLEEP]; // RQ6
  assign clamp_source_sel = control_ff[`ACR_CTL_CLAMP_SRC]; // RQ7
  assign signed_output_sel = control_ff[`ACR_CTL_SIGNED]; // RQ8
  assign clamp_out_off = control_ff[`ACR_CTL_CLAMP_OFF]; // RQ9
  // code 000 maps to bottom reference, 3FF to top; analog side scales
  assign clamp_code = {clamp_high_ff[1:0], clamp_low_ff}; // RQ10 RQ11

  // output path carries conversions only, never register contents
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      dout_ff <= 10'h000;
      over_range_ff <= 1'b0;
    end else if (ce) begin
      // offset binary to two's complement is an msb flip
      dout_ff <= {conv_result[9] ^ signed_output_sel, conv_result[8:0]}; // RQ3 RQ8 RQ14
      over_range_ff <= conv_over_range;
    end
  end

  // enable is active low while the device drives
  assign data_out = dout_ff;
  assign over_range_out = over_range_ff;
  assign data_oe_n = oe_n_s; // RQ12 RQ14
  assign over_range_oe_n = oe_n_s;

  // a control write shows up in the register one cycle after commit
  property p_wr_commit;
    @(posedge clk_sys) disable iff (rst)
    (ce && commit && word_ff[9:8] == `ACR_SEL_CONTROL) |=>
      (control_ff == $past(word_ff[7:0]));
  endproperty
  a_wr_commit: assert property (p_wr_commit) else $error("control not written"); // RQ2

  // reserved destination must leave every register as it was
  property p_reserved;
    @(posedge clk_sys) disable iff (rst)
    (commit && word_ff[9:8] == `ACR_SEL_RESERVED) |=>
      $stable(control_ff) && $stable(clamp_low_ff) && $stable(clamp_high_ff);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved write changed state"); // RQ15

  // without a completed strobe nothing may move
  property p_no_wr_no_change;
    @(posedge clk_sys) disable iff (rst)
    !commit |=> $stable(clamp_low_ff) && $stable(clamp_high_ff) && $stable(control_ff);
  endproperty
  a_no_wr_no_change: assert property (p_no_wr_no_change) else $error("spurious write"); // RQ13

  // clamp high payload bits 1:0 become code bits 9:8
  property p_code;
    @(posedge clk_sys) disable iff (rst)
    (ce && commit && word_ff[9:8] == `ACR_SEL_CLAMP_HIGH) |=>
      (clamp_code[9:8] == $past(word_ff[1:0]));
  endproperty
  a_code: assert property (p_code) else $error("clamp code mismatch"); // RQ10

  // clamp low payload becomes code bits 7:0, top bits untouched
  property p_code_low;
    @(posedge clk_sys) disable iff (rst)
    (ce && commit && word_ff[9:8] == `ACR_SEL_CLAMP_LOW) |=>
      (clamp_code[7:0] == $past(word_ff[7:0])) && $stable(clamp_code[9:8]);
  endproperty
  a_code_low: assert property (p_code_low) else $error("clamp low byte not written"); // RQ10

  // gain stays within half to four, and code 001 is unity
  property p_gain;
    @(posedge clk_sys) disable iff (rst)
    (gain_half_steps >= 4'h1) && (gain_half_steps <= 4'h8) &&
      ((gain_select != 3'h1) || (gain_half_steps == 4'h2));
  endproperty
  a_gain: assert property (p_gain) else $error("gain decode wrong"); // RQ5

  // output word is last cycle's result, msb flipped in signed mode
  property p_format;
    @(posedge clk_sys) disable iff (rst)
    ce |=> (data_out[9] == ($past(conv_result[9]) ^ $past(signed_output_sel))) &&
      (data_out[8:0] == $past(conv_result[8:0]));
  endproperty
  a_format: assert property (p_format) else $error("output format wrong"); // RQ8

  // no driving on the shared pins while a word is being captured
  property p_hiz;
    @(posedge clk_sys) disable iff (rst)
    (st_ff == acr_pkg::ACR_HIGH) |-> data_oe_n && over_range_oe_n;
  endproperty
  a_hiz: assert property (p_hiz) else $error("drove pins during write"); // RQ12

  // a strobe seen while the device drives is not a write
  property p_refused;
    @(posedge clk_sys) disable iff (rst)
    (st_ff == acr_pkg::ACR_IDLE && wr_s && !oe_n_s) |=> (st_ff == acr_pkg::ACR_IDLE);
  endproperty
  a_refused: assert property (p_refused) else $error("write taken while driving"); // RQ12

  // control write lands power-down and clamp-off bits in place
  property p_sleep;
    @(posedge clk_sys) disable iff (rst)
    (ce && commit && word_ff[9:8] == `ACR_SEL_CONTROL) |=>
      (sleep_bit == $past(word_ff[3])) && (clamp_out_off == $past(word_ff[6]));
  endproperty
  a_sleep: assert property (p_sleep) else $error("control bit mapping wrong"); // RQ6 RQ9
endmodule : acr_regs

// ### verif/acr_host.sv
`timescale 1ns/1ps
// host side of the shared pins; every change lands on a falling edge
module acr_host (
  input wire logic clk_sys,
  output logic wr_pin,
  output logic oe_n_pin,
  output logic [9:0] data_in
);
  initial begin
    wr_pin = 1'b0;
    oe_n_pin = 1'b1;
    data_in = 10'h3FF;
  end
  // drive enable level, for tests of the output path
  task automatic drive_enable(input logic v);
    oe_n_pin = v;
  endtask : drive_enable
  // one write; code 11 goes out only when a test asks for it
  task automatic write_word(input logic [9:0] word, input logic oe_n);
    oe_n_pin = oe_n;
    // let the device see the enable and release the pins first
    repeat (4) @(negedge clk_sys);
    data_in = word;
    repeat (2) @(negedge clk_sys);
    wr_pin = 1'b1;
    repeat (6) @(negedge clk_sys);
    wr_pin = 1'b0;
    repeat (6) @(negedge clk_sys);
    // a released bus floats; never leave the old word showing
    data_in = ~word;
    repeat (4) @(negedge clk_sys);
  endtask : write_word
endmodule : acr_host

// ### verif/acr_regs_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD %0t mismatch %h vs %h", $time, a, e); end end
module acr_regs_test;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [9:0] conv_result = 10'h000;
  logic conv_over_range = 1'b0;
  logic wr_pin, oe_n_pin, data_oe_n, over_range_out, over_range_oe_n;
  logic sleep_bit, clamp_source_sel, signed_output_sel, clamp_out_off;
  logic [9:0] data_in, data_out, clamp_code;
  logic [2:0] gain_select;
  logic [3:0] gain_half_steps;
  int fail_count = 0;
  int compares = 0;
  // write words beside the clamp code and control byte they leave behind
  logic [9:0] w_tab [13] = '{10'h00F, 10'h101, 10'h1FE, 10'h0FF, 10'h103, 10'h200,
    10'h209, 10'h212, 10'h223, 10'h244, 10'h2FD, 10'h206, 10'h207};
  logic [9:0] c_tab [13] = '{10'h00F, 10'h10F, 10'h20F, 10'h2FF, 10'h3FF, 10'h3FF,
    10'h3FF, 10'h3FF, 10'h3FF, 10'h3FF, 10'h3FF, 10'h3FF, 10'h3FF};
  logic [7:0] k_tab [13] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00,
    8'h09, 8'h12, 8'h23, 8'h44, 8'h7D, 8'h06, 8'h07};
  // 100 MHz clock
  always #5 clk_sys = ~clk_sys;
  acr_host u_acr_host (.clk_sys(clk_sys), .wr_pin(wr_pin), .oe_n_pin(oe_n_pin),
    .data_in(data_in));
  acr_regs u_acr_regs (.clk_sys(clk_sys), .rst(rst), .ce(ce), .wr_pin(wr_pin),
    .oe_n_pin(oe_n_pin), .data_in(data_in), .data_out(data_out), .data_oe_n(data_oe_n),
    .over_range_out(over_range_out), .over_range_oe_n(over_range_oe_n),
    .conv_result(conv_result), .conv_over_range(conv_over_range),
    .gain_select(gain_select), .gain_half_steps(gain_half_steps), .sleep_bit(sleep_bit),
    .clamp_source_sel(clamp_source_sel), .signed_output_sel(signed_output_sel),
    .clamp_out_off(clamp_out_off), .clamp_code(clamp_code));
  // verdict and end of run
  task automatic wrap_up;
    if (fail_count == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up
  // compare every register-driven level; bit 7 of control is unused
  task automatic check_regs(input logic [9:0] code, input logic [7:0] k);
    `CHK(clamp_code, code)
    `CHK(gain_select, k[2:0])
    `CHK(gain_half_steps, {1'b0, k[2:0]} + 4'h1)
    `CHK(sleep_bit, k[3])
    `CHK(clamp_source_sel, k[4])
    `CHK(signed_output_sel, k[5])
    `CHK(clamp_out_off, k[6])
  endtask : check_regs
  // watchdog sized well above the whole sequence
  initial begin
    repeat (3000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (5) @(negedge clk_sys);
    rst = 1'b0;
    check_regs(10'h000, 8'h01);
    `CHK(data_oe_n, 1'b1)
    for (int i = 0; i < 13; i++) begin
      u_acr_host.write_word(w_tab[i], 1'b1);
      check_regs(c_tab[i], k_tab[i]);
    end
    // reserved destination leaves everything alone
    u_acr_host.write_word(10'h3AA, 1'b1);
    check_regs(10'h3FF, 8'h07);
    `CHK(data_oe_n, 1'b1)
    `CHK(over_range_oe_n, 1'b1)
    // strobe while the device drives the pins is not a write
    u_acr_host.write_word(10'h000, 1'b0);
    check_regs(10'h3FF, 8'h07);
    conv_result = 10'h2C5;
    conv_over_range = 1'b1;
    repeat (3) @(negedge clk_sys);
    `CHK(data_oe_n, 1'b0)
    `CHK(data_out, 10'h2C5)
    `CHK(over_range_out, 1'b1)
    `CHK(over_range_oe_n, 1'b0)
    // switch to two's complement and look again
    u_acr_host.write_word(10'h220, 1'b1);
    u_acr_host.drive_enable(1'b0);
    repeat (8) @(negedge clk_sys);
    `CHK(data_out, 10'h0C5)
    // second reset in mid-run restores defaults
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    check_regs(10'h000, 8'h01);
    `CHK(data_out, 10'h000)
    `CHK(data_oe_n, 1'b1)
    @(negedge clk_sys);
    `CHK(data_out, 10'h2C5)
    // clock enable low freezes capture and the output path
    ce = 1'b0;
    conv_result = 10'h000;
    u_acr_host.write_word(10'h0AA, 1'b1);
    check_regs(10'h000, 8'h01);
    `CHK(data_out, 10'h2C5)
    ce = 1'b1;
    repeat (8) @(negedge clk_sys);
    check_regs(10'h000, 8'h01);
    `CHK(data_out, 10'h000)
    wrap_up();
  end
endmodule : acr_regs_test
